//--- bscd_core.sv
`timescale 1ns/1ns
// Summary of operation
// - Prefix 01 11 decodes the bit-test-skip-if-set, with bit field b then register address f.
// - If the tested bit is one the next instruction is skipped, else execution goes on in order.
// - A taken skip discards the prefetched word and runs a no-op, so it takes two cycles, else one.
// - Prefix 100 decodes the call, whose 11-bit literal goes into program counter bits 10 to 0.
// - The call pushes the address after the call onto the top of the return stack first.
// - The call copies high-latch bits 4 and 3 into program counter bits 12 and 11.
// - The call takes two cycles and leaves every status flag alone.
// - Clear-register writes zero to the addressed file register, sets zero flag, in one cycle.
module bscd_core
  import bscd_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // Fetch stage
  input  wire logic [INSN_W-1:0]    insn_word,
  input  wire logic                 insn_valid,
  // Register file read port and high latch
  input  wire logic [DATA_W-1:0]    file_rd_data,
  input  wire logic [DATA_W-1:0]    pc_high_latch,
  // Register file access
  output logic [FADDR_W-1:0]        file_addr,
  output logic                      file_wr_en,
  output logic [DATA_W-1:0]         file_wr_data,
  // Stack push
  output logic                      push_en,
  output logic [PC_W-1:0]           top_of_stack_entry,
  // Status flag update
  output logic                      zero_flag_set,
  // Program counter and fetch control
  output logic [PC_W-1:0]           pc,
  output logic                      flush
);

  bscd_state_t          state;
  bscd_state_t          next_state;
  logic [PC_W-1:0]      next_pc;
  logic [FADDR_W-1:0]   next_file_addr;
  logic                 next_file_wr_en;
  logic                 next_push_en;
  logic [PC_W-1:0]      next_top_of_stack_entry;
  logic                 next_zero_flag_set;
  logic                 next_flush;
  logic [DATA_W-1:0]    next_file_wr_data;
  logic                 is_skip;
  logic                 is_call;
  logic                 is_clear;
  logic [BIT_SEL_W-1:0] bit_sel;

  // Opcode decode; file_rd_data is the register addressed by the current word
  assign is_skip  = insn_word[OPC4_HI:OPC4_LO] == OPC_BIT_TEST_SKIP_IF_SET;
  assign is_call  = insn_word[OPC4_HI:OPC3_LO] == OPC_CALL;
  assign is_clear = insn_word[OPC4_HI:OPC7_LO] == OPC_CLEAR_FILE_REGISTER;
  assign bit_sel  = insn_word[BIT_SEL_HI:BIT_SEL_LO];

  // pc names the next fetch address, so it leads the word being executed by the prefetch.
  // A taken skip or a call therefore burns one slot in which pc still steps by one; the word on
  // insn_word in that slot is never decoded, which is what turns it into a no-op.
  // Trade-off: the slot does not look at insn_valid, so a stalled fetch still advances pc.
  // Next-state logic; the second cycle of a taken skip or a call is a flush slot that only steps
  always_comb begin
    next_state              = BSCD_EXEC;
    next_pc                 = pc;
    next_file_addr          = insn_word[FADDR_HI:0];
    next_file_wr_en         = 1'b0;
    next_push_en            = 1'b0;
    next_top_of_stack_entry = top_of_stack_entry;
    next_zero_flag_set      = 1'b0;
    next_file_wr_data       = ZERO_DATA;
    next_flush              = 1'b0;
    unique case (state)
      BSCD_EXEC: begin
        if (insn_valid) begin
          if (is_skip) begin
            next_pc = pc + PC_STEP;
            if (file_rd_data[bit_sel]) begin
              // Prefetched word is thrown away and a no-op slot follows
              next_state = BSCD_FLUSH;
              next_flush = 1'b1;
            end
          end else if (is_call) begin
            next_push_en            = 1'b1;
            next_top_of_stack_entry = pc + PC_STEP;
            next_pc = {pc_high_latch[LATCH_HI:LATCH_LO],
                       insn_word[LIT_HI:0]};
            next_state = BSCD_FLUSH;
            next_flush = 1'b1;
          end else if (is_clear) begin
            // Write data is a fixed zero, so only the enable and address carry the word
            next_file_wr_en    = 1'b1;
            next_zero_flag_set = 1'b1;
            next_pc            = pc + PC_STEP;
          end else begin
            next_pc = pc + PC_STEP;
          end
        end
      end
      BSCD_FLUSH: begin
        // No-op cycle: the word on insn_word is ignored
        next_pc = pc + PC_STEP;
      end
      default: begin
        next_state = BSCD_EXEC;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state              <= BSCD_EXEC;
      pc                 <= PC_RESET;
      file_addr          <= '0;
      file_wr_en         <= 1'b0;
      push_en            <= 1'b0;
      top_of_stack_entry <= PC_RESET;
      zero_flag_set      <= 1'b0;
      flush              <= 1'b0;
      file_wr_data       <= ZERO_DATA;
    end else begin
      state              <= next_state;
      pc                 <= next_pc;
      file_addr          <= next_file_addr;
      file_wr_en         <= next_file_wr_en;
      push_en            <= next_push_en;
      top_of_stack_entry <= next_top_of_stack_entry;
      zero_flag_set      <= next_zero_flag_set;
      flush              <= next_flush;
      // Kept in a flop so every output of the block is registered
      file_wr_data       <= next_file_wr_data;
    end
  end

  // Checks on the decoder's own outputs
  AST_SKIP_TAKEN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_skip && file_rd_data[bit_sel])
      |=> flush && state == BSCD_FLUSH)
    else $error("taken skip did not flush");
  AST_SKIP_NOT_TAKEN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_skip && !file_rd_data[bit_sel])
      |=> !flush && pc == $past(pc) + PC_STEP && !zero_flag_set)
    else $error("plain bit-test misbehaved");
  AST_SKIP_TWO_CYCLES: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_skip && file_rd_data[bit_sel])
      |=> state == BSCD_FLUSH ##1 (state == BSCD_EXEC && !file_wr_en && !push_en))
    else $error("skip slot not exactly one no-op");
  AST_CALL_TARGET: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_call)
      |=> pc[LIT_HI:0] == $past(insn_word[LIT_HI:0]))
    else $error("call literal not loaded");
  AST_CALL_PUSH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_call)
      |=> push_en && top_of_stack_entry == $past(pc) + PC_STEP)
    else $error("call return address wrong");
  AST_CALL_HIGH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_call)
      |=> pc[PC_W-1:CALL_LIT_W] == $past(pc_high_latch[LATCH_HI:LATCH_LO]))
    else $error("call high bits wrong");
  AST_CALL_TWO_CYCLES: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_call)
      |=> (!zero_flag_set && state == BSCD_FLUSH) ##1 (state == BSCD_EXEC && !push_en))
    else $error("call not two cycles or touched flags");
  AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_clear)
      |=> file_wr_en && zero_flag_set && file_wr_data == ZERO_DATA
          && file_addr == $past(insn_word[FADDR_HI:0]) && state == BSCD_EXEC)
    else $error("clear-register misbehaved");
  AST_DECODE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_skip) |=> !file_wr_en && !push_en)
    else $error("bit-test wrote state");

  // Each kind of cycle raises only its own pulses; these catch a pulse leaking
  // from one instruction kind into another, which the per-instruction checks miss

  // The no-op slot after a skip or call steps pc and raises nothing, whatever word is offered
  AST_SLOT_NOOP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_FLUSH)
      |=> state == BSCD_EXEC && pc == $past(pc) + PC_STEP && !flush
          && !file_wr_en && !push_en && !zero_flag_set)
    else $error("no-op slot did work");

  // Words outside the three decoded groups only step the counter
  AST_OTHER_WORD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && !is_skip && !is_call && !is_clear)
      |=> pc == $past(pc) + PC_STEP && !flush && !file_wr_en && !push_en && !zero_flag_set)
    else $error("undecoded word had an effect");

  // With no word to run in an execute cycle the decoder holds pc and raises nothing
  AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && !insn_valid)
      |=> pc == $past(pc) && !flush && !file_wr_en && !push_en && !zero_flag_set)
    else $error("idle cycle changed state");

  // Only a clear may raise the zero flag; skip and call leave flags alone
  AST_FLAG_SOURCE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    zero_flag_set |-> file_wr_en && file_wr_data == ZERO_DATA && !push_en && !flush)
    else $error("zero flag raised outside a clear");

  // A push always comes with its slot flush and carries the counter after the call
  AST_PUSH_WITH_FLUSH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    push_en |-> flush && state == BSCD_FLUSH && top_of_stack_entry == $past(pc) + PC_STEP)
    else $error("push without its slot");

  // The clear finishes in one cycle: no slot follows it
  AST_CLEAR_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_clear)
      |=> !flush && pc == $past(pc) + PC_STEP)
    else $error("clear took more than one cycle");

  // A bit-test of either outcome leaves the status flags alone
  AST_SKIP_NO_FLAGS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_skip)
      |=> !zero_flag_set)
    else $error("bit-test touched a flag");

  // The second cycle of a call only steps on from the loaded target
  AST_CALL_SLOT_STEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == BSCD_EXEC && insn_valid && is_call)
      |=> ##1 (pc == $past(pc) + PC_STEP && !flush && !zero_flag_set))
    else $error("call slot did not step");

endmodule : bscd_core

//--- bscd_file_model.sv
`timescale 1ns/1ns
module bscd_file_model
  import bscd_pkg::*;
(
  // Clock
  input  wire logic               clk_sys,
  // Read port, combinational as the block expects
  input  wire logic [FADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0]  rd_data,
  // Write port driven by the block
  input  wire logic [FADDR_W-1:0] wr_addr,
  input  wire logic               wr_en,
  input  wire logic [DATA_W-1:0]  wr_data
);
  logic [DATA_W-1:0] mem [0:127];

  // Seeded with a mixed pattern so both skip outcomes and a clear show up
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'h5A ^ 8'(i);
  end

  // Same-cycle read, no latency
  assign rd_data = mem[rd_addr];

  // Writes land on the edge that sees the pulse
  always @(posedge clk_sys) begin
    if (wr_en) mem[wr_addr] <= wr_data;
  end
endmodule : bscd_file_model

//--- bscd_pkg.sv
package bscd_pkg;
  // Instruction word layout
  localparam int INSN_W     = 14;
  localparam int PC_W       = 13;
  localparam int FADDR_W    = 7;
  localparam int DATA_W     = 8;
  localparam int BIT_SEL_W  = 3;
  localparam int CALL_LIT_W = 11;
  // Opcode prefixes
  localparam logic [3:0] OPC_BIT_TEST_SKIP_IF_SET = 4'h7;           // 01 11
  localparam logic [2:0] OPC_CALL                 = 3'h4;           // 100
  localparam logic [6:0] OPC_CLEAR_FILE_REGISTER  = 7'h03;          // 00 0001 1
  // Field positions
  localparam int OPC4_HI    = 13;
  localparam int OPC4_LO    = 10;
  localparam int OPC3_LO    = 11;
  localparam int OPC7_LO    = 7;
  localparam int BIT_SEL_LO = 7;
  localparam int BIT_SEL_HI = 9;
  localparam int FADDR_HI   = 6;
  localparam int LIT_HI     = 10;
  localparam int LATCH_HI   = 4;
  localparam int LATCH_LO   = 3;
  // Constants
  localparam logic [INSN_W-1:0] NOP_WORD  = 14'h0000;
  localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
  localparam logic [PC_W-1:0]   PC_STEP   = 13'h0001;

  typedef enum logic [1:0] {
    BSCD_EXEC  = 2'b01,
    BSCD_FLUSH = 2'b10
  } bscd_state_t;
endpackage : bscd_pkg

//--- test_bit_skip_call_clear_decode.sv
`timescale 1ns/1ns
module test_bit_skip_call_clear_decode
  import bscd_pkg::*;
;
  logic               clk_sys       = 1'b0;
  logic               reset_n       = 1'b0;
  logic [INSN_W-1:0]  insn_word     = NOP_WORD;
  logic               insn_valid    = 1'b0;
  logic [DATA_W-1:0]  pc_high_latch = ZERO_DATA;
  logic [DATA_W-1:0]  file_rd_data, file_wr_data;
  logic [FADDR_W-1:0] file_addr;
  logic               file_wr_en, push_en, zero_flag_set, flush;
  logic [PC_W-1:0]    pc, top_of_stack_entry, pc0;
  int                 num_errors    = 0;
  int                 check_count   = 0;
  int                 cycles        = 0;

  bscd_core u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .insn_word(insn_word), .insn_valid(insn_valid),
    .file_rd_data(file_rd_data), .pc_high_latch(pc_high_latch), .file_addr(file_addr), .file_wr_en(file_wr_en),
    .file_wr_data(file_wr_data), .push_en(push_en), .top_of_stack_entry(top_of_stack_entry),
    .zero_flag_set(zero_flag_set), .pc(pc), .flush(flush));
  bscd_file_model u_file (.clk_sys(clk_sys), .rd_addr(insn_word[FADDR_W-1:0]), .rd_data(file_rd_data),
    .wr_addr(file_addr), .wr_en(file_wr_en), .wr_data(file_wr_data));

  // Clock and a ceiling well above the roughly 32 cycles the run needs
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Word stays up until the next call overwrites it, so no signal changes twice per step
  task automatic exec(input logic [INSN_W-1:0] w);
    insn_word  = w;
    insn_valid = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask : exec

  task automatic idle();
    insn_valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : idle

  // Every bit of one register; a taken skip gets a clear word in its slot that must be dropped
  task automatic bit_test_scenario();
    logic [DATA_W-1:0] val;
    val = 8'h5A ^ 8'h11;
    for (int b = 0; b < 8; b++) begin
      pc0 = pc;
      exec({OPC_BIT_TEST_SKIP_IF_SET, 3'(b), 7'h11});
      check("flush", 16'(val[b]), 16'(flush));
      check("pc", 16'(pc0 + PC_STEP), 16'(pc));
      check("zero_flag_set", 16'h0000, 16'(zero_flag_set));
      if (val[b]) begin
        exec({OPC_CLEAR_FILE_REGISTER, 7'h22});
        check("slot file_wr_en", 16'h0000, 16'(file_wr_en));
        check("slot flush", 16'h0000, 16'(flush));
        check("slot pc", 16'(pc0 + PC_STEP + PC_STEP), 16'(pc));
      end
    end
    idle();
  endtask : bit_test_scenario

  // Two latch settings, 4:3 at 11 then 00, the second with stray bits outside 4:3
  task automatic call_scenario();
    logic [PC_W-1:0] target;
    for (int i = 0; i < 2; i++) begin
      pc_high_latch = i ? 8'hE7 : 8'h18;
      target = {pc_high_latch[4:3], 11'h5A3 ^ 11'(i)};
      pc0 = pc;
      exec({OPC_CALL, target[10:0]});
      check("push_en", 16'h0001, 16'(push_en));
      check("top_of_stack_entry", 16'(pc0 + PC_STEP), 16'(top_of_stack_entry));
      check("pc", 16'(target), 16'(pc));
      check("flush", 16'h0001, 16'(flush));
      check("zero_flag_set", 16'h0000, 16'(zero_flag_set));
      exec(NOP_WORD);
      check("slot pc", 16'(target + PC_STEP), 16'(pc));
      check("slot push_en", 16'h0000, 16'(push_en));
    end
    idle();
  endtask : call_scenario

  // Near misses of each prefix: skip-if-clear, a jump and clear-working-register only step pc
  task automatic decode_scenario();
    logic [INSN_W-1:0] words [3];
    words = '{{4'h6, 3'h0, 7'h11}, {3'h5, 11'h123}, 14'h0103};
    for (int i = 0; i < 3; i++) begin
      pc0 = pc;
      exec(words[i]);
      check("near flush", 16'h0000, 16'(flush));
      check("near push_en", 16'h0000, 16'(push_en));
      check("near file_wr_en", 16'h0000, 16'(file_wr_en));
      check("near zero_flag_set", 16'h0000, 16'(zero_flag_set));
      check("near pc", 16'(pc0 + PC_STEP), 16'(pc));
    end
    idle();
  endtask : decode_scenario

  // Highest address; pulses last one cycle and pc holds while idle
  task automatic clear_scenario();
    pc0 = pc;
    exec({OPC_CLEAR_FILE_REGISTER, 7'h7F});
    check("file_wr_en", 16'h0001, 16'(file_wr_en));
    check("file_addr", 16'h007F, 16'(file_addr));
    check("file_wr_data", 16'(ZERO_DATA), 16'(file_wr_data));
    check("zero_flag_set", 16'h0001, 16'(zero_flag_set));
    check("flush", 16'h0000, 16'(flush));
    check("pc", 16'(pc0 + PC_STEP), 16'(pc));
    idle();
    check("file_wr_en after", 16'h0000, 16'(file_wr_en));
    check("zero_flag_set after", 16'h0000, 16'(zero_flag_set));
    check("cleared register", 16'(ZERO_DATA), 16'(u_file.mem[7'h7F]));
    check("pc idle", 16'(pc0 + PC_STEP), 16'(pc));
  endtask : clear_scenario

  // Reset for 8 cycles, released just after an edge
  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    bit_test_scenario();
    call_scenario();
    decode_scenario();
    clear_scenario();
    conclude();
  end
endmodule : test_bit_skip_call_clear_decode
